/* File: design/mwsf_pkg.sv */
// Purpose: shared constants for the meter warning status flags block
// Assumes: axi4-lite slave, 32-bit data, aligned word registers
// Notes: offsets and bit positions named here only
package mwsf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_RAW = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_CHECKSUM_REF = 8'h14;
    localparam int ADDR_W = 8;
    // status word bit positions
    localparam int BIT_G2_CS = 10;
    localparam int BIT_G3_CS = 8;
    localparam int BIT_VSEQ = 7;
    localparam int BIT_ISEQ = 6;
    localparam int BIT_DIP = 3;
    localparam int BIT_PLOSS = 2;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_MASK = 16'h05cc;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [15:0] CS_REF_RESET = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // one-hot bus states
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } mwsf_wr_state_t;
endpackage : mwsf_pkg

/* File: design/mwsf_sync_if.sv */
// Purpose: carrier for synchronised detector levels
// Assumes: single clock
// Notes: level driven by the synchroniser, read by the top; raw driven by the top, read by the synchroniser
`timescale 1ns/1ps
interface mwsf_sync_if;
    logic [5:0] raw;
    logic [5:0] level;
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface : mwsf_sync_if

/* File: design/mwsf_sync2.sv */
// Purpose: two-flop synchroniser for detector inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module mwsf_sync2 (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    mwsf_sync_if.sync sif
);
    logic [5:0] meta;
    logic [5:0] next_meta;
    logic [5:0] next_level;
    logic [5:0] level_q;
    // next values
    always_comb begin
        next_meta = sif.raw;
        next_level = meta;
    end
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 6'h00;
            level_q <= 6'h00;
        end else begin
            meta <= next_meta;
            level_q <= next_level;
        end
    end
    assign sif.level = level_q;
endmodule : mwsf_sync2

/* File: design/mwsf_top.sv */
// Purpose: lower warning status flags with warning pin and axi4-lite access
// Assumes: detectors outside drive level inputs; checksums compared here
// Notes: flags follow their detectors; irq status is sticky
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module mwsf_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [mwsf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [mwsf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // checksum results from the calibration engines
    input wire logic [15:0] group2_checksum,
    input wire logic [15:0] group3_checksum,
    input wire logic [15:0] group2_checksum_calc,
    input wire logic [15:0] group3_checksum_calc,
    // detector levels, asynchronous
    input wire logic voltage_sequence_fault,
    input wire logic current_sequence_fault,
    input wire logic voltage_dip_flag,
    input wire logic phase_missing_flag,
    // pins and interrupt
    output logic warning_output_pin,
    output logic irq
);
    import mwsf_pkg::*;

    mwsf_sync_if sif ();
    logic g2_bad;
    logic g3_bad;
    logic [15:0] status;
    logic [15:0] next_status;
    logic [15:0] irq_sts;
    logic [15:0] next_irq_sts;
    logic [15:0] irq_en;
    logic [15:0] next_irq_en;
    logic [15:0] cs_ref;
    logic [15:0] next_cs_ref;
    logic [15:0] irq_clr;
    logic warn;
    logic next_warn;

    // detector inputs are async; checksum mismatch flags join them
    assign g2_bad = (group2_checksum != group2_checksum_calc);
    assign g3_bad = (group3_checksum != group3_checksum_calc);
    assign sif.raw = {g2_bad, g3_bad, voltage_sequence_fault, current_sequence_fault,
                      voltage_dip_flag, phase_missing_flag};

    mwsf_sync2 u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif)
    );

    // status word follows detectors; reserved bits never set
    always_comb begin
        next_status = STATUS_RESET;
        next_status[BIT_G2_CS] = sif.level[5];
        next_status[BIT_G3_CS] = sif.level[4];
        next_status[BIT_VSEQ] = sif.level[3];
        next_status[BIT_ISEQ] = sif.level[2];
        next_status[BIT_DIP] = sif.level[1];
        next_status[BIT_PLOSS] = sif.level[0];
        next_status = next_status & STATUS_MASK;
        // pin set from the same next value so it rises with the flag
        next_warn = next_status[BIT_G2_CS] | next_status[BIT_G3_CS];
    end

    // write channel: take aw and w in either order, then respond
    mwsf_wr_state_t wr_state;
    mwsf_wr_state_t next_wr_state;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic do_write;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [15:0] wmask;

    assign s_axi_awready = (wr_state == WR_IDLE) && !aw_held;
    assign s_axi_wready = (wr_state == WR_IDLE) && !w_held;
    assign s_axi_bvalid = (wr_state == WR_RESP);
    assign s_axi_bresp = bresp;
    // a channel beat moves when valid meets ready
    logic aw_take;
    logic w_take;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        do_write = 1'b0;
        case (wr_state)
            WR_IDLE: begin
                if (aw_take) begin
                    next_aw_held = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                end
                if (w_take) begin
                    next_w_held = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                end
                if (next_aw_held && next_w_held) begin
                    do_write = 1'b1;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = WR_IDLE;
                end
            end
            default: begin
                next_wr_state = WR_IDLE;
            end
        endcase
    end

    // write payload as seen in the cycle it completes
    assign wa = next_aw_addr;
    assign wd = next_w_data;
    assign ws = next_w_strb;
    assign wmask = {{8{ws[1]}}, {8{ws[0]}}};

    // write address decode; read-only words take the write and ignore it
    logic wsel_en;
    logic wsel_clr;
    logic wsel_ref;
    logic wsel_ro;
    assign wsel_en = (wa == OFS_IRQ_ENABLE);
    assign wsel_clr = (wa == OFS_IRQ_CLEAR);
    assign wsel_ref = (wa == OFS_CHECKSUM_REF);
    assign wsel_ro = (wa == OFS_STATUS) || (wa == OFS_RAW) || (wa == OFS_IRQ_STATUS);

    // rising flag edges are the events; a level held high sets nothing new
    logic [15:0] status_rise;
    assign status_rise = (next_status & ~status) & STATUS_MASK;

    // register writes; hardware set beats software clear
    always_comb begin
        next_irq_en = irq_en;
        next_cs_ref = cs_ref;
        next_bresp = do_write ? RESP_OKAY : bresp;
        irq_clr = 16'h0000;
        if (do_write) begin
            if (wsel_en) begin
                next_irq_en = ((irq_en & ~wmask) | (wd[15:0] & wmask)) & STATUS_MASK;
            end else if (wsel_clr) begin
                irq_clr = wd[15:0] & wmask;
            end else if (wsel_ref) begin
                next_cs_ref = (cs_ref & ~wmask) | (wd[15:0] & wmask);
            end else if (wsel_ro) begin
                next_bresp = RESP_OKAY; // read-only, write ignored
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        // clear goes first so an event in the same cycle still lands
        next_irq_sts = ((irq_sts & ~irq_clr) | status_rise) & STATUS_MASK;
    end

    // read channel: one-cycle answer held until rready
    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;

    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // read request and completion, then address decode; the rest is refused
    logic ar_take;
    logic r_done;
    logic rsel_status;
    logic rsel_raw;
    logic rsel_irq_sts;
    logic rsel_irq_en;
    logic rsel_ref;
    logic rsel_clr;
    assign ar_take = s_axi_arvalid && !rvalid;
    assign r_done = rvalid && s_axi_rready;
    assign rsel_status = (s_axi_araddr == OFS_STATUS);
    assign rsel_raw = (s_axi_araddr == OFS_RAW);
    assign rsel_irq_sts = (s_axi_araddr == OFS_IRQ_STATUS);
    assign rsel_irq_en = (s_axi_araddr == OFS_IRQ_ENABLE);
    assign rsel_ref = (s_axi_araddr == OFS_CHECKSUM_REF);
    assign rsel_clr = (s_axi_araddr == OFS_IRQ_CLEAR);

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (r_done) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = ZERO32;
            if (rsel_status) begin
                next_rdata = {16'h0000, status};
            end else if (rsel_raw) begin
                next_rdata = {26'h0000000, sif.level};
            end else if (rsel_irq_sts) begin
                next_rdata = {16'h0000, irq_sts};
            end else if (rsel_irq_en) begin
                next_rdata = {16'h0000, irq_en};
            end else if (rsel_ref) begin
                next_rdata = {16'h0000, cs_ref};
            end else if (rsel_clr) begin
                next_rdata = ZERO32; // write-only
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
    end

    // all state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= STATUS_RESET;
            warn <= 1'b0;
            irq_sts <= 16'h0000;
            irq_en <= 16'h0000;
            cs_ref <= CS_REF_RESET;
            wr_state <= WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= ZERO32;
            w_strb <= 4'h0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= ZERO32;
            rresp <= RESP_OKAY;
        end else begin
            status <= next_status;
            warn <= next_warn;
            irq_sts <= next_irq_sts;
            irq_en <= next_irq_en;
            cs_ref <= next_cs_ref;
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign warning_output_pin = warn;
    // level interrupt while any enabled sticky bit stands
    assign irq = |(irq_sts & irq_en);
endmodule : mwsf_top

/* File: sim/mwsf_assertions.sv */
// Purpose: port checks for the warning status flags
// Assumes: one clock, sync reset, three edge flag path
// Notes: status bits show only in read data
`timescale 1ns/1ps
module mwsf_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read channel
    input wire logic [mwsf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // checksums and pin
    input wire logic [15:0] group2_checksum,
    input wire logic [15:0] group3_checksum,
    input wire logic [15:0] group2_checksum_calc,
    input wire logic [15:0] group3_checksum_calc,
    input wire logic warning_output_pin
);
    import mwsf_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_take;
    logic cs_bad;
    // read request taken at this edge
    assign ar_take = s_axi_arvalid && s_axi_arready;
    // either checksum group disagrees with its computed value
    assign cs_bad = (group2_checksum != group2_checksum_calc) || (group3_checksum != group3_checksum_calc);
    // mismatch held long enough to cross the sync path
    sequence g2_bad_s; (group2_checksum != group2_checksum_calc)[*3]; endsequence
    sequence g3_bad_s; (group3_checksum != group3_checksum_calc)[*3]; endsequence
    sequence all_ok_s; (!cs_bad)[*3]; endsequence
    g2_pin_a: assert property (g2_bad_s |=> warning_output_pin) else $error("pin low on group2 fault");
    g3_pin_a: assert property (g3_bad_s |=> warning_output_pin) else $error("pin low on group3 fault");
    pin_quiet_a: assert property (all_ok_s |=> !warning_output_pin) else $error("pin high without fault");
    pin_cause_a: assert property ($rose(warning_output_pin) |-> $past(cs_bad, 3))
        else $error("pin rose without cause");
    pin_flag_a: assert property (ar_take && s_axi_araddr == OFS_STATUS |=> (s_axi_rdata[10] || s_axi_rdata[8])
        == $past(warning_output_pin)) else $error("pin and flags differ");
    rsvd_zero_a: assert property (ar_take && s_axi_araddr == OFS_STATUS |=> (s_axi_rdata & ~{16'h0, STATUS_MASK})
        == ZERO32) else $error("reserved bits set");
    unmapped_a: assert property (ar_take && s_axi_araddr > OFS_CHECKSUM_REF |=> s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == ZERO32) else $error("unmapped read not refused");
    read_answer_a: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
endmodule : mwsf_checker
bind mwsf_top mwsf_checker mwsf_checker_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .group2_checksum(group2_checksum),
    .group3_checksum(group3_checksum), .group2_checksum_calc(group2_checksum_calc),
    .group3_checksum_calc(group3_checksum_calc), .warning_output_pin(warning_output_pin));

/* File: sim/meter_warning_status_flags_bench.sv */
// Purpose: directed bench for the warning status flags
// Assumes: axi4-lite master tasks, one clock
// Notes: a level needs three edges to show, four are waited
`timescale 1ns/1ps
module meter_warning_status_flags_bench;
    import mwsf_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] g2 = 16'h1234, g3 = 16'h5678, g2c = 16'h1234, g3c = 16'h5678;
    logic [3:0] det = 4'h0;
    int bits[4] = '{BIT_PLOSS, BIT_DIP, BIT_ISEQ, BIT_VSEQ};
    int error_cnt = 0;
    int checks_done = 0;
    mwsf_top mwsf_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .group2_checksum(g2),
        .group3_checksum(g3), .group2_checksum_calc(g2c), .group3_checksum_calc(g3c),
        .voltage_sequence_fault(det[3]), .current_sequence_fault(det[2]), .voltage_dip_flag(det[1]),
        .phase_missing_flag(det[0]), .warning_output_pin(pin), .irq(irq));
    // free running clock
    always #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // the wr and rd tasks open on a fresh edge so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready === 1'b1) aw_ok = 1'b1;
            if (wready === 1'b1) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "bresp");
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, exp, what);
        chk({30'h0, rresp}, {30'h0, er}, what);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // watchdog, tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        results();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_STATUS, ZERO32, RESP_OKAY, "status reset");
        chk({31'h0, pin}, ZERO32, "pin reset");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            det <= 4'h1 << i;
            repeat (4) @(posedge aclk);
            rd(OFS_STATUS, 32'h1 << bits[i], RESP_OKAY, "detector bit");
        end
        det <= 4'h0;
        $display("test detectors done");
        g2c <= 16'h1235;
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, 32'h400, RESP_OKAY, "group2 fault");
        chk({31'h0, pin}, 32'h1, "pin group2");
        g2c <= 16'h1234;
        g3c <= 16'h0000;
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, 32'h100, RESP_OKAY, "group3 fault");
        chk({31'h0, pin}, 32'h1, "pin group3");
        g3c <= 16'h5678;
        repeat (4) @(posedge aclk);
        chk({31'h0, pin}, ZERO32, "pin clear");
        $display("test checksums done");
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS, ZERO32, RESP_OKAY, "reserved");
        rd(8'h40, ZERO32, RESP_SLVERR, "unmapped");
        wr(OFS_CHECKSUM_REF, 32'h0000_a5c3);
        rd(OFS_CHECKSUM_REF, 32'h0000_a5c3, RESP_OKAY, "scratch");
        det <= 4'h5;
        g3c <= 16'h0000;
        repeat (4) @(posedge aclk);
        rd(OFS_RAW, 32'h0000_0015, RESP_OKAY, "raw levels");
        rd(OFS_STATUS, 32'h0000_0144, RESP_OKAY, "mixed flags");
        det <= 4'h0;
        g3c <= 16'h5678;
        repeat (4) @(posedge aclk);
        $display("test access done");
        wr(OFS_IRQ_CLEAR, 32'hffff);
        wr(OFS_IRQ_ENABLE, 32'h80);
        rd(OFS_IRQ_ENABLE, 32'h80, RESP_OKAY, "enable");
        chk({31'h0, irq}, ZERO32, "irq idle");
        det <= 4'h8;
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(OFS_IRQ_ENABLE, ZERO32);
        chk({31'h0, irq}, ZERO32, "irq masked");
        det <= 4'h0;
        repeat (4) @(posedge aclk);
        rd(OFS_IRQ_STATUS, 32'h80, RESP_OKAY, "sticky");
        wr(OFS_IRQ_CLEAR, 32'h80);
        rd(OFS_IRQ_STATUS, ZERO32, RESP_OKAY, "cleared");
        rd(OFS_IRQ_CLEAR, ZERO32, RESP_OKAY, "clear reads zero");
        $display("test interrupt done");
        results();
    end
endmodule : meter_warning_status_flags_bench
